/* File: hdl/rhs_holdoff_counter.sv */
/*
 * Hold-off down-counter with a power-of-two prescaler.
 * Assumes the controller asserts run only while a hold-off countdown is wanted.
 */
`timescale 1ns/10ps
module rhs_holdoff_counter (
   input  wire logic                           clk_sys_i,
   input  wire logic                           srst_i,
   input  wire logic                           run_i,
   input  wire logic                           load_i,
   input  wire logic [rhs_pkg::HOLD_W-1:0]     start_i,
   input  wire logic [rhs_pkg::PRESCALE_W-1:0] prescale_i,
   output logic                                expire_o,
   output logic [rhs_pkg::HOLD_W-1:0]          count_o
);
   import rhs_pkg::*;

   logic [PRE_CNT_W-1:0] pre_q;
   logic [PRE_CNT_W-1:0] ratio_m1;
   logic [HOLD_W-1:0]    cnt_q;
   logic                 expire_q;

   assign ratio_m1 = (32'h1 << prescale_i) - 32'h1;
   assign expire_o = expire_q;
   assign count_o  = cnt_q;

   // -----------------------------------------------------------------------
   // Countdown
   // -----------------------------------------------------------------------
   // One count per prescaled tick; expiry reloads the start value.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pre_q    <= '0;
         cnt_q    <= '0;
         expire_q <= 1'b0;
      end else begin
         expire_q <= 1'b0;
         if (load_i) begin
            cnt_q <= start_i;
            pre_q <= '0;
         end else if (run_i) begin
            if (cnt_q == 8'h00) begin
               expire_q <= 1'b1;
               cnt_q    <= start_i;
               pre_q    <= '0;
            end else if (pre_q == ratio_m1) begin
               pre_q <= '0;
               cnt_q <= cnt_q - 8'h01;
            end else begin
               pre_q <= pre_q + 32'h1;
            end
         end
      end
   end

endmodule

/* File: hdl/rhs_pkg.sv */
/*
 * Constants, register map and state encoding for the reference holdover selector.
 * Assumes an 8-bit register port and two redundant reference inputs.
 */
package rhs_pkg;

   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 8;
   localparam int WORD_W     = 16;
   localparam int NUM_IN     = 2;
   localparam int PRESCALE_W = 5;
   localparam int PRE_CNT_W  = 32;
   localparam int HOLD_W     = 8;
   localparam int REVAL_W    = 11;

   // -----------------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_HOLDOFF  = 8'h01;
   localparam logic [ADDR_W-1:0] REG_PRESCALE = 8'h02;
   localparam logic [ADDR_W-1:0] REG_REVAL    = 8'h03;
   localparam logic [ADDR_W-1:0] REG_PRIORITY = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h05;
   localparam logic [ADDR_W-1:0] REG_LOSS     = 8'h06;
   localparam logic [ADDR_W-1:0] REG_COUNT    = 8'h07;

   // -----------------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------------
   localparam int CTRL_HO_BIT   = 0;
   localparam int CTRL_AM_LSB   = 1;
   localparam int CTRL_SRC_BIT  = 3;
   localparam int CTRL_ISEL_BIT = 4;
   localparam int CTRL_REVERTIVE_ENABLE_BIT = 5;
   localparam int ST_VALID_LSB  = 0;
   localparam int ST_HOLDN_BIT  = 2;
   localparam int ACTIVE_INPUT_INDICATOR_BIT    = 3;
   localparam int REFERENCE_VALID_STATUS_BIT    = 4;
   localparam int LOSS_REF_BIT  = 2;

   // -----------------------------------------------------------------------
   // Reset values and mode codes
   // -----------------------------------------------------------------------
   localparam logic [5:0]            CTRL_RST     = 6'h00;
   localparam logic [HOLD_W-1:0]     HOLDOFF_RST  = 8'h08;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 5'h02;
   localparam logic [1:0]            REVAL_RST    = 2'h2;
   localparam logic [3:0]            PRIORITY_RST = 4'h1;
   localparam logic [1:0]            AM_SHORT     = 2'h2;
   localparam logic [1:0]            AM_AUTO_HOLD = 2'h3;

   // Clock cycles per step of the revalidation setting.
   localparam logic [REVAL_W-1:0]    REVAL_UNIT   = 11'h100;

   typedef enum logic [2:0] {
      ST_TRACK = 3'b001,
      ST_COUNT = 3'b010,
      ST_STALL = 3'b100
   } rhs_state_e;

endpackage

/* File: hdl/rhs_selector.sv */
/*
 * Reference selection and holdover controller for a two-input clock cleaner.
 * Assumes LOS flags come from a detector on clk_sys_i, the select pin is
 * asynchronous, and the PLL tuning word is on clk_sys_i.
 */
// Functional notes
// - Short-term holdover mode enters holdover at once when selected reference fails.
// - Short-term holdover selection follows only the user pin or bit.
// - Short-term mode revalidates by setting, then relocks to the same input.
// - Auto holdover mode: LOS or manual change starts holdover and countdown, then switch only if active input is lost.
// - Holdover lasts start value times prescaler ratio over VCXO frequency.
// - Auto holdover ends early on primary revalidation or manual selection change.
// - Manual holdover mode selects from pin or bit, chosen by select source.
// - Manual change enters holdover until the 8-bit counter expires, then switches.
// - Manual mode: holdover flag 0 during holdover, selection and inputs tracked.
// - Auto mode LOS on active input at once starts holdover, clears status and latch.
// - During countdown both inputs stay monitored and new losses are flagged.
// - Revalidation in countdown: status high, latch clearable, selection kept, no revert.
// - Expiry with active input valid keeps it, reference status 1, holdover ends.
// - Expiry with active lost and other valid switches, status 1, holdover ends.
// - Expiry with nothing valid keeps selection, status low, refuses clear, stays held.
// - After hold-off completes revertive switching works again when enabled.
// - In holdover the output follows a stored tuning word from earlier lock.
// - Expired hold-off counter reloads its programmed start value.
// - Revertive off after reset; revert only to a higher priority input.
`timescale 1ns/10ps
module rhs_selector (
   input  wire logic                        clk_sys_i,
   input  wire logic                        srst_i,
   input  wire logic [rhs_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [rhs_pkg::DATA_W-1:0]  wr_data_i,
   input  wire logic                        wr_en_i,
   input  wire logic                        rd_en_i,
   output logic      [rhs_pkg::DATA_W-1:0]  rd_data_o,
   input  wire logic [rhs_pkg::NUM_IN-1:0]  los_i,
   input  wire logic                        external_select_pin_i,
   input  wire logic [rhs_pkg::WORD_W-1:0]  pll_word_i,
   output logic      [rhs_pkg::WORD_W-1:0]  tuning_word_o,
   output logic                             holdover_active_n_o,
   output logic                             active_input_indicator_o,
   output logic                             reference_valid_status_o,
   output logic      [rhs_pkg::NUM_IN-1:0]  input_valid_status_o
);
   import rhs_pkg::*;

   // -----------------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------------
   logic [5:0]            ctrl_q;
   logic [HOLD_W-1:0]     holdoff_start_value_q;
   logic [PRESCALE_W-1:0] holdoff_prescaler_q;
   logic [1:0]            revalidation_setting_q;
   logic [3:0]            priority_q;
   logic [NUM_IN-1:0]     input_loss_latch_q;
   logic                  reference_loss_latch_q;
   logic [NUM_IN-1:0]     input_valid_status_q;
   logic [NUM_IN-1:0]     valid_prev_q;
   logic                  reference_valid_status_q;
   logic                  holdover_active_n_q;
   logic [WORD_W-1:0]     tuning_word_q;
   logic [DATA_W-1:0]     rd_data_q;
   logic                  ext_meta_q;
   logic                  ext_sync_q;
   logic                  user_sel_prev_q;
   logic                  cause_loss_q;
   logic                  cause_loss_d;
   rhs_state_e            state_q;
   rhs_state_e            state_d;
   logic                  sel_q;
   logic                  sel_d;
   logic                  load_hold;
   logic                  hold_expire;
   logic [HOLD_W-1:0]     hold_count;
   logic                  holdover_mode_select_n;
   logic [1:0]            auto_manual_field;
   logic                  mode_manual_ho;
   logic                  mode_short;
   logic                  mode_auto_ho;
   logic                  user_sel;
   logic                  user_change;
   logic                  sel_bad;
   logic                  other;
   logic                  revert_ok;
   logic [NUM_IN-1:0]     loss_event;
   logic [NUM_IN-1:0]     valid_rise;
   logic                  wr_loss;
   logic                  ref_next;
   logic [1:0]            prio_sel;
   logic [1:0]            prio_other;

   assign holdover_mode_select_n = ctrl_q[CTRL_HO_BIT];
   assign auto_manual_field      = ctrl_q[CTRL_AM_LSB +: 2];
   assign mode_manual_ho         = !holdover_mode_select_n;
   assign mode_short             = holdover_mode_select_n && (auto_manual_field == AM_SHORT);
   assign mode_auto_ho           = holdover_mode_select_n && (auto_manual_field == AM_AUTO_HOLD);

   // -----------------------------------------------------------------------
   // Select pin synchroniser and user choice
   // -----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ext_meta_q      <= 1'b0;
         ext_sync_q      <= 1'b0;
         user_sel_prev_q <= 1'b0;
      end else begin
         ext_meta_q      <= external_select_pin_i;
         ext_sync_q      <= ext_meta_q;
         user_sel_prev_q <= user_sel;
      end
   end

   // Pin or register bit, as picked by the select source bit.
   assign user_sel    = ctrl_q[CTRL_SRC_BIT] ? ctrl_q[CTRL_ISEL_BIT] : ext_sync_q;
   assign user_change = (user_sel != user_sel_prev_q);
   assign other       = !sel_q;
   assign sel_bad     = los_i[sel_q] || !input_valid_status_q[sel_q];
   assign prio_sel    = priority_q[{sel_q, 1'b0} +: 2];
   assign prio_other  = priority_q[{other, 1'b0} +: 2];
   assign revert_ok   = ctrl_q[CTRL_REVERTIVE_ENABLE_BIT] && valid_rise[other] &&
                        (prio_other > prio_sel);

   // -----------------------------------------------------------------------
   // Per-input revalidation and loss latches
   // -----------------------------------------------------------------------
   assign wr_loss = wr_en_i && (addr_i == REG_LOSS);

   generate
      for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_input
         logic [REVAL_W-1:0] good_cnt_q;
         logic [REVAL_W-1:0] good_limit;

         assign good_limit     = REVAL_UNIT * ({9'h000, revalidation_setting_q} + 11'h001);
         assign loss_event[gi] = los_i[gi] && input_valid_status_q[gi];
         assign valid_rise[gi] = input_valid_status_q[gi] && !valid_prev_q[gi];

         // An input is valid again after LOS stays away for the set time.
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               good_cnt_q               <= '0;
               input_valid_status_q[gi] <= 1'b0;
               valid_prev_q[gi]         <= 1'b0;
            end else begin
               valid_prev_q[gi] <= input_valid_status_q[gi];
               if (los_i[gi]) begin
                  good_cnt_q               <= '0;
                  input_valid_status_q[gi] <= 1'b0;
               end else if (!input_valid_status_q[gi]) begin
                  if (good_cnt_q >= good_limit - 11'h001) begin
                     input_valid_status_q[gi] <= 1'b1;
                  end else begin
                     good_cnt_q <= good_cnt_q + 11'h001;
                  end
               end
            end
         end

         // A new loss wins over a clear; clear only once the input is valid.
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               input_loss_latch_q[gi] <= 1'b0;
            end else if (loss_event[gi]) begin
               input_loss_latch_q[gi] <= 1'b1;
            end else if (wr_loss && wr_data_i[gi] && input_valid_status_q[gi]) begin
               input_loss_latch_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------------
   // Selection and holdover state machine
   // -----------------------------------------------------------------------
   always_comb begin
      state_d      = state_q;
      sel_d        = sel_q;
      load_hold    = 1'b0;
      cause_loss_d = cause_loss_q;
      case (state_q)
         ST_TRACK: begin
            if (mode_manual_ho) begin
               if (user_sel != sel_q) begin
                  state_d   = ST_COUNT;
                  load_hold = 1'b1;
               end
            end else if (mode_short) begin
               sel_d = user_sel;
               if (los_i[user_sel] || !input_valid_status_q[user_sel]) begin
                  state_d = ST_STALL;
               end
            end else if (mode_auto_ho) begin
               if (sel_bad || user_change) begin
                  state_d      = ST_COUNT;
                  load_hold    = 1'b1;
                  cause_loss_d = sel_bad;
               end else if (revert_ok) begin
                  sel_d = other;
               end
            end else begin
               sel_d = user_sel;
            end
         end
         ST_COUNT: begin
            if (mode_manual_ho) begin
               if (hold_expire) begin
                  sel_d   = user_sel;
                  state_d = ST_TRACK;
               end
            end else if (mode_auto_ho) begin
               if (user_change && !cause_loss_q) begin
                  sel_d   = user_sel;
                  state_d = ST_TRACK;
               end else if (user_change) begin
                  sel_d   = user_sel;
                  state_d = ST_TRACK;
               end else if (cause_loss_q && input_valid_status_q[sel_q] && !los_i[sel_q]) begin
                  state_d = ST_TRACK;
               end else if (hold_expire) begin
                  if (input_valid_status_q[sel_q] && !los_i[sel_q]) begin
                     state_d = ST_TRACK;
                  end else if (input_valid_status_q[other] && !los_i[other]) begin
                     sel_d   = other;
                     state_d = ST_TRACK;
                  end else begin
                     state_d = ST_STALL;
                  end
               end
            end else begin
               state_d = ST_TRACK;
            end
         end
         ST_STALL: begin
            if (mode_short) begin
               sel_d = user_sel;
               if (input_valid_status_q[user_sel] && !los_i[user_sel]) begin
                  state_d = ST_TRACK;
               end
            end else if (mode_auto_ho) begin
               if (user_change) begin
                  sel_d   = user_sel;
                  state_d = ST_TRACK;
               end else if (input_valid_status_q[sel_q] && !los_i[sel_q]) begin
                  state_d = ST_TRACK;
               end else if (input_valid_status_q[other] && !los_i[other]) begin
                  sel_d   = other;
                  state_d = ST_TRACK;
               end
            end else begin
               state_d = ST_TRACK;
            end
         end
         default: begin
            state_d = ST_TRACK;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_q      <= ST_TRACK;
         sel_q        <= 1'b0;
         cause_loss_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         sel_q        <= sel_d;
         cause_loss_q <= cause_loss_d;
      end
   end

   rhs_holdoff_counter u_holdoff (
      .clk_sys_i  (clk_sys_i),
      .srst_i     (srst_i),
      .run_i      (state_q == ST_COUNT),
      .load_i     (load_hold),
      .start_i    (holdoff_start_value_q),
      .prescale_i (holdoff_prescaler_q),
      .expire_o   (hold_expire),
      .count_o    (hold_count)
   );

   // -----------------------------------------------------------------------
   // Status flags and reference loss latch
   // -----------------------------------------------------------------------
   // In manual holdover mode the reference status tracks the selected input.
   assign ref_next = input_valid_status_q[sel_d] && !los_i[sel_d] &&
                     (mode_manual_ho || (state_d == ST_TRACK));

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         reference_valid_status_q <= 1'b0;
         holdover_active_n_q      <= 1'b1;
      end else begin
         reference_valid_status_q <= ref_next;
         holdover_active_n_q      <= (state_d == ST_TRACK);
      end
   end

   // Low means a loss was seen on the reference; loss wins over a clear.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         reference_loss_latch_q <= 1'b1;
      end else if ((mode_auto_ho || mode_short) && loss_event[sel_q]) begin
         reference_loss_latch_q <= 1'b0;
      end else if (wr_loss && wr_data_i[LOSS_REF_BIT] && reference_valid_status_q) begin
         reference_loss_latch_q <= 1'b1;
      end
   end

   // The tuning word freezes on the last locked value while in holdover.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         tuning_word_q <= '0;
      end else if (state_q == ST_TRACK && reference_valid_status_q) begin
         tuning_word_q <= pll_word_i;
      end
   end

   // -----------------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ctrl_q                 <= CTRL_RST;
         holdoff_start_value_q  <= HOLDOFF_RST;
         holdoff_prescaler_q    <= PRESCALE_RST;
         revalidation_setting_q <= REVAL_RST;
         priority_q             <= PRIORITY_RST;
      end else if (wr_en_i) begin
         case (addr_i)
            REG_CTRL:     ctrl_q                 <= wr_data_i[5:0];
            REG_HOLDOFF:  holdoff_start_value_q  <= wr_data_i;
            REG_PRESCALE: holdoff_prescaler_q    <= wr_data_i[PRESCALE_W-1:0];
            REG_REVAL:    revalidation_setting_q <= wr_data_i[1:0];
            REG_PRIORITY: priority_q             <= wr_data_i[3:0];
            default: begin
            end
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // Register reads
   // -----------------------------------------------------------------------
   // Read data stand for one cycle only; unmapped offsets read zero.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rd_data_q <= 8'h00;
      end else if (rd_en_i) begin
         case (addr_i)
            REG_CTRL:     rd_data_q <= {2'h0, ctrl_q};
            REG_HOLDOFF:  rd_data_q <= holdoff_start_value_q;
            REG_PRESCALE: rd_data_q <= {3'h0, holdoff_prescaler_q};
            REG_REVAL:    rd_data_q <= {6'h00, revalidation_setting_q};
            REG_PRIORITY: rd_data_q <= {4'h0, priority_q};
            REG_STATUS:   rd_data_q <= {3'h0, reference_valid_status_q, sel_q,
                                        holdover_active_n_q, input_valid_status_q};
            REG_LOSS:     rd_data_q <= {5'h00, reference_loss_latch_q, input_loss_latch_q};
            REG_COUNT:    rd_data_q <= hold_count;
            default:      rd_data_q <= 8'h00;
         endcase
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   assign rd_data_o                = rd_data_q;
   assign tuning_word_o            = tuning_word_q;
   assign holdover_active_n_o      = holdover_active_n_q;
   assign active_input_indicator_o = sel_q;
   assign reference_valid_status_o = reference_valid_status_q;
   assign input_valid_status_o     = input_valid_status_q;

endmodule

/* File: testbench/rhs_ref_model.sv */
/* Model of the two redundant reference inputs and their loss detector.
   Assumes the bench commands outages on clk_sys_i. */
`timescale 1ns/10ps
module rhs_ref_model (
   input  wire logic       clk_sys_i,
   input  wire logic [1:0] fail_i,
   output logic      [1:0] los_o
);
   // A dead reference shows as loss one edge after it stops.
   always_ff @(posedge clk_sys_i) begin
      los_o <= fail_i;
   end
endmodule

/* File: testbench/rhs_selector_chk.sv */
/* Port assertions for the reference holdover selector.
   Assumes a bind into rhs_selector and one clock domain. */
`timescale 1ns/10ps
module rhs_selector_chk (
   input wire logic                       clk_sys_i,
   input wire logic                       srst_i,
   input wire logic [rhs_pkg::ADDR_W-1:0] addr_i,
   input wire logic                       rd_en_i,
   input wire logic [rhs_pkg::DATA_W-1:0] rd_data_o,
   input wire logic [rhs_pkg::NUM_IN-1:0] los_i,
   input wire logic [rhs_pkg::WORD_W-1:0] tuning_word_o,
   input wire logic                       holdover_active_n_o,
   input wire logic                       active_input_indicator_o,
   input wire logic                       reference_valid_status_o,
   input wire logic [rhs_pkg::NUM_IN-1:0] input_valid_status_o
);
   import rhs_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   sequence s_hold_start;
      $fell(holdover_active_n_o);
   endsequence
   a_status_read: assert property (rd_en_i && addr_i == REG_STATUS |=>
      rd_data_o[4:0] == {$past(reference_valid_status_o), $past(active_input_indicator_o),
      $past(holdover_active_n_o), $past(input_valid_status_o)}) else $error("status read");
   a_tune_frozen: assert property (!holdover_active_n_o && !$past(holdover_active_n_o)
      |-> $stable(tuning_word_o)) else $error("tuning word moved in holdover");
   a_loss_drops_valid: assert property (|los_i |=>
      (input_valid_status_o & $past(los_i)) == 2'h0) else $error("lost input still valid");
   a_ref_needs_sel: assert property (reference_valid_status_o |->
      input_valid_status_o[active_input_indicator_o]) else $error("ref valid on bad input");
   a_sel_outside_hold: assert property ($changed(active_input_indicator_o)
      |-> holdover_active_n_o) else $error("selection moved in holdover");
   a_hold_min_len: assert property (s_hold_start |=> !holdover_active_n_o [*8])
      else $error("holdover too short");
   a_ref_low_los: assert property (los_i[active_input_indicator_o] |=>
      !reference_valid_status_o || $changed(active_input_indicator_o))
      else $error("ref valid despite loss");
   a_valid_settle: assert property ($rose(input_valid_status_o[0])
      |-> !$past(los_i[0], 8)) else $error("input valid too soon");
endmodule

/* File: testbench/testbench.sv */
/* Self-checking bench for rhs_selector with reference model and checker.
   Assumes register reset values and field layout of rhs_pkg. */
`timescale 1ns/10ps
module testbench;
   import rhs_pkg::*;
   logic clk_sys_i = 0, srst_i = 1, wr_en_i = 0, rd_en_i = 0;
   logic [7:0] addr_i = 0, wr_data_i = 0, rd_data_o;
   logic [1:0] fail = 0, los_i, input_valid_status_o;
   logic external_select_pin = 0;
   logic [7:0] tw;
   logic [15:0] pll_word_i = 0, tuning_word_o;
   logic holdover_active_n_o, active_input_indicator_o, reference_valid_status_o;
   wire [7:0] fl = {6'h00, holdover_active_n_o, active_input_indicator_o};
   logic [15:0] rows [7] = '{16'h0000, 16'h0108, 16'h0202, 16'h0302, 16'h0401, 16'h0504,
      16'hFF00};
   int n_fail = 0, checks = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) pll_word_i <= pll_word_i + 16'h0001;
   rhs_ref_model u_rhs_ref_model (.clk_sys_i, .fail_i(fail), .los_o(los_i));
   rhs_selector u_rhs_selector (.clk_sys_i, .srst_i, .addr_i, .wr_data_i, .wr_en_i,
      .rd_en_i, .rd_data_o, .los_i, .external_select_pin_i(external_select_pin), .pll_word_i,
      .tuning_word_o, .holdover_active_n_o, .active_input_indicator_o,
      .reference_valid_status_o, .input_valid_status_o);
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= w;
      rd_en_i <= !w;
      @(posedge clk_sys_i);
      wr_en_i <= 1'h0;
      rd_en_i <= 1'h0;
      @(negedge clk_sys_i);
      if (!w) chk("rd_data_o", d, rd_data_o);
   endtask
   task automatic wait_sel(logic s);
      for (int i = 0; i < 60 && active_input_indicator_o !== s; i++) @(negedge clk_sys_i);
   endtask
   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #30us;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'h0;
      foreach (rows[i]) bus(1'h0, rows[i][15:8], rows[i][7:0]);
      repeat (800) @(posedge clk_sys_i);
      bus(1'h0, REG_STATUS, 8'h17);
      bus(1'h1, REG_CTRL, 8'h18);
      repeat (20) @(negedge clk_sys_i);
      chk("hold_n,sel", 8'h00, fl);
      wait_sel(1'h1);
      chk("hold_n,sel", 8'h03, fl);
      bus(1'h1, REG_CTRL, 8'h1F);
      @(posedge clk_sys_i) fail <= 2'h2;
      repeat (3) @(negedge clk_sys_i);
      chk("hold_n,sel", 8'h01, fl);
      chk("valid", 8'h01, {6'h00, input_valid_status_o});
      wait_sel(1'h0);
      bus(1'h0, REG_STATUS, 8'h15);
      chk("tune_lo", pll_word_i[7:0] - 8'h01, tuning_word_o[7:0]);
      bus(1'h0, REG_LOSS, 8'h02);
      bus(1'h1, REG_LOSS, 8'h06);
      bus(1'h0, REG_LOSS, 8'h06);
      @(posedge clk_sys_i) fail <= 2'h3;
      repeat (60) @(negedge clk_sys_i);
      chk("hold_n,sel", 8'h00, fl);
      tw = tuning_word_o[7:0];
      repeat (5) @(negedge clk_sys_i);
      chk("tune_hold", tw, tuning_word_o[7:0]);
      bus(1'h1, REG_LOSS, 8'h04);
      bus(1'h0, REG_LOSS, 8'h03);
      @(posedge clk_sys_i) srst_i <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      srst_i <= 1'h0;
      bus(1'h0, REG_CTRL, 8'h00);
      chk("hold_n,sel", 8'h02, fl);
      @(posedge clk_sys_i) external_select_pin <= 1'h1;
      wait_sel(1'h1);
      chk("hold_n,sel", 8'h03, fl);
      @(posedge clk_sys_i) fail <= 2'h0;
      repeat (800) @(negedge clk_sys_i);
      bus(1'h1, REG_CTRL, 8'h05);
      @(posedge clk_sys_i) fail <= 2'h2;
      repeat (3) @(negedge clk_sys_i);
      chk("hold_n,sel", 8'h01, fl);
      bus(1'h0, REG_STATUS, 8'h09);
      @(posedge clk_sys_i) fail <= 2'h0;
      repeat (800) @(negedge clk_sys_i);
      bus(1'h0, REG_STATUS, 8'h1F);
      wrap_up();
   end
endmodule
bind rhs_selector rhs_selector_chk u_rhs_selector_chk (.*);
